/* core/pdc_pkg.sv */
// Constants for the PLL phase and output gate controller.
// Assumes one 10 MHz system clock; one tick models an eighth of a VCO cycle.
package pdc_pkg;
  localparam int NUM_OUT = 4;
  localparam int DIV_W = 8;
  localparam int FPH_W = 3;
  localparam int CPH_W = 8;
  localparam int AMT_W = 20;
  localparam int ADR_W = 8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TICKS_PER_VCO = 8;
  localparam int SETUP_NS = 1;
  localparam int HOLD_VCO = 5;
  localparam int STEP_MIN_VCO = 4;
  localparam int CLK_NS = 100;
  localparam int LOAD_MIN_NS = 10;
  localparam int LOAD_MIN_RAW = (LOAD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_MIN_CYC = (LOAD_MIN_RAW < 1) ? 1 : LOAD_MIN_RAW;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_CFG0 = 8'h10;
  localparam int CTRL_ACT = 0;
  localparam int CTRL_FBK = 4;
  localparam int CTRL_FBDIV = 8;
  localparam int CFG_DIV = 0;
  localparam int CFG_FPH = 8;
  localparam int CFG_CPH = 16;
  localparam int ST_EN = 0;
  localparam int ST_PICK = 4;
  localparam int ST_DIR = 6;
  localparam int ST_FCNT = 8;
  localparam int ST_CCNT = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_010F;
  localparam logic [31:0] CTRL_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CFG_RST = 32'h0001_0101;
  localparam logic [31:0] CFG_MASK = 32'h00FF_07FF;
  localparam logic [7:0] FB_DIV_MIN = 8'h01;
  localparam logic [7:0] FB_DIV_MAX = 8'h80;
  // ----------------------------------------
  // Output indices, pick codes, sync bits
  // ----------------------------------------
  localparam logic [1:0] IDX_PRI = 2'h0;
  localparam logic [1:0] IDX_SEC = 2'h1;
  localparam logic [1:0] IDX_THR = 2'h2;
  localparam logic [1:0] IDX_FOU = 2'h3;
  localparam logic [1:0] PICK_SEC = 2'h0;
  localparam logic [1:0] PICK_THR = 2'h1;
  localparam logic [1:0] PICK_FOU = 2'h2;
  localparam int SY_PICK = 0;
  localparam int SY_DIR = 2;
  localparam int SY_STEP = 3;
  localparam int SY_LOAD = 4;
  localparam int SY_GATE = 5;
  localparam int SY_W = 9;

  function automatic logic [1:0] pick_to_idx(input logic [1:0] code);
    case (code)
      PICK_SEC: pick_to_idx = IDX_SEC;
      PICK_THR: pick_to_idx = IDX_THR;
      PICK_FOU: pick_to_idx = IDX_FOU;
      default: pick_to_idx = IDX_PRI;
    endcase
  endfunction : pick_to_idx
endpackage : pdc_pkg

/* core/pdc_out_div.sv */
// One output divider with phase shifting by tick count.
// Assumes shift requests are single-cycle pulses on clk_sys.
`timescale 1ns/100ps
module pdc_out_div #(
  parameter int DIV_W = 8,
  parameter int AMT_W = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [DIV_W-1:0] div_val,
  input wire logic shift_req,
  input wire logic shift_adv,
  input wire logic [AMT_W-1:0] shift_amt,
  output logic clk_out,
  output logic fall
);
  localparam int CW = DIV_W + 3;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [AMT_W-1:0] stall;
    logic out;
    logic fall;
  } pdc_div_st_t;
  pdc_div_st_t q, d;
  logic [DIV_W-1:0] div_eff;
  logic [CW-1:0] per;
  logic [CW-1:0] amt_m;
  logic [CW:0] sum;

  always_comb begin
    div_eff = (div_val == '0) ? DIV_W'(1) : div_val;
    per = {div_eff, 3'h0};
    amt_m = CW'(shift_amt % AMT_W'(per));
    d = q;
    // Count runs on in the shift cycle too, so a shift moves by exactly amt_m
    if (q.stall != '0) begin
      d.stall = q.stall - AMT_W'(1);
    end else begin
      d.cnt = (q.cnt + CW'(1) >= per) ? '0 : q.cnt + CW'(1);
    end
    sum = {1'b0, d.cnt} + {1'b0, amt_m};
    if (shift_req && shift_adv) begin
      d.cnt = (sum >= {1'b0, per}) ? CW'(sum - {1'b0, per}) : sum[CW-1:0];
    end else if (shift_req) begin
      d.stall = d.stall + AMT_W'(amt_m);
    end
    d.out = d.cnt < (per >> 1);
    d.fall = q.out & ~d.out;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_out = q.out;
  assign fall = q.fall;
endmodule : pdc_out_div

/* core/pdc_clk_gate.sv */
// Glitchless gate for one divided output clock.
// Assumes clk_in and prim_fall come from flops on clk_sys.
`timescale 1ns/100ps
module pdc_clk_gate (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_in,
  input wire logic gate_req,
  input wire logic prim_fall,
  input wire logic always_on,
  input wire logic active,
  output logic clk_out,
  output logic enabled
);
  typedef struct packed {
    logic en;
    logic arm;
    logic out;
  } pdc_gate_st_t;
  pdc_gate_st_t q, d;

  always_comb begin
    d = q;
    if (!active) begin
      d.en = 1'b0;
      d.arm = 1'b0;
    end else if (always_on) begin
      d.en = 1'b1;
      d.arm = 1'b0;
    end else if (gate_req && !q.en) begin
      // armed at primary fall; an output high then waits for its low
      if ((prim_fall || q.arm) && !clk_in) begin
        d.en = 1'b1;
        d.arm = 1'b0;
      end else if (prim_fall) begin
        d.arm = 1'b1;
      end
    end else if (!gate_req) begin
      d.arm = 1'b0;
      if (q.en && !clk_in) begin
        d.en = 1'b0;
      end
    end
    d.out = clk_in & d.en;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_out = q.out;
  assign enabled = q.en;
endmodule : pdc_clk_gate

/* core/pdc_pll_ctrl.sv */
// PLL dynamic phase control and output clock gating, top level.
// Assumes fabric pins are asynchronous and a classic Wishbone master.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps

// Summary of operation
// - Only the output named by the pick code is adjusted.
// - Direction and pick code are latched on the step rising edge.
// - Fine step shifts by fine setting over eight times divide value.
// - Direction 0 delays; pick code 00 chooses the secondary output.
// - Delaying shifts never glitch; advancing shifts may glitch.
// - Divider shift moves phase by coarse minus divide over divide plus one.
// - Coarse and divide both 1 give no shift.
// - Each output has its own glitchless enable.
// - A disabled output is held low.
// - A re-enabled output restarts at a primary falling edge.
// - Feedback or inactive outputs ignore their enable input.
// - Feedback divide value ranges 1 to 128, default 1.
// - Codes 00,01,10,11 pick secondary, third, fourth, primary.
// - Direction 1 advances the chosen output.
// - Divider shift starts at pulse falling edge; pulse lasts 10 ns.
module pdc_pll_ctrl #(
  parameter int ADR_W = pdc_pkg::ADR_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] output_pick_code,
  input wire logic shift_direction,
  input wire logic fine_step_pulse,
  input wire logic divider_shift_pulse,
  input wire logic primary_out_gate,
  input wire logic secondary_out_gate,
  input wire logic third_out_gate,
  input wire logic fourth_out_gate,
  output logic primary_out_clock,
  output logic secondary_out_clock,
  output logic third_out_clock,
  output logic fourth_out_clock
);
  localparam int N = pdc_pkg::NUM_OUT;
  localparam int AW = pdc_pkg::AMT_W;
  localparam int DW = pdc_pkg::DIV_W;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [pdc_pkg::SY_W-1:0] meta;
    logic [pdc_pkg::SY_W-1:0] sync;
    logic step_prev;
    logic load_prev;
    logic [7:0] load_len;
    logic [1:0] cap_pick;
    logic cap_dir;
    logic [31:0] ctrl;
    logic [N-1:0][31:0] cfg;
    logic [7:0] fine_cnt;
    logic [7:0] crs_cnt;
    logic ack;
    logic [31:0] rdat;
  } pdc_top_st_t;

  pdc_top_st_t q, d;

  logic [pdc_pkg::SY_W-1:0] pins;
  logic step_now;
  logic load_now;
  logic step_rise;
  logic fine_fire;
  logic crs_fire;
  logic [1:0] fine_idx;
  logic [1:0] crs_idx;
  logic [N-1:0] shift_req;
  logic [N-1:0] shift_adv;
  logic [N-1:0][AW-1:0] shift_amt;
  logic [N-1:0][AW-1:0] crs_amt;
  logic [N-1:0] crs_adv;
  logic [N-1:0] div_clk;
  logic [N-1:0] div_fall;
  logic [N-1:0] gate_clk;
  logic [N-1:0] gate_en;
  logic [N-1:0] active;
  logic [N-1:0] fbk;
  logic wb_hit;
  logic [ADR_W-1:0] cfg_off;
  logic [7:0] fb_new;
  logic [31:0] wmerge;

  function automatic logic [31:0] merge_sel(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    merge_sel = res & mask;
  endfunction : merge_sel

  // ----------------------------------------
  // Pin gathering
  // ----------------------------------------
  always_comb begin
    pins = '0;
    pins[pdc_pkg::SY_PICK +: 2] = output_pick_code;
    pins[pdc_pkg::SY_DIR] = shift_direction;
    pins[pdc_pkg::SY_STEP] = fine_step_pulse;
    pins[pdc_pkg::SY_LOAD] = divider_shift_pulse;
    pins[pdc_pkg::SY_GATE + 0] = primary_out_gate;
    pins[pdc_pkg::SY_GATE + 1] = secondary_out_gate;
    pins[pdc_pkg::SY_GATE + 2] = third_out_gate;
    pins[pdc_pkg::SY_GATE + 3] = fourth_out_gate;
  end

  assign active = q.ctrl[pdc_pkg::CTRL_ACT +: N];
  assign fbk = q.ctrl[pdc_pkg::CTRL_FBK +: N];

  // ----------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------
  always_comb begin
    step_now = q.sync[pdc_pkg::SY_STEP];
    load_now = q.sync[pdc_pkg::SY_LOAD];
    step_rise = step_now & ~q.step_prev;
    // Shift lands on the falling edge, using values latched at rise
    fine_fire = q.step_prev & ~step_now;
    // start on falling edge, short pulses dropped
    crs_fire = q.load_prev & ~load_now
      & (q.load_len >= 8'(pdc_pkg::LOAD_MIN_CYC));
    fine_idx = pdc_pkg::pick_to_idx(q.cap_pick);
    crs_idx = pdc_pkg::pick_to_idx(q.sync[pdc_pkg::SY_PICK +: 2]);
  end

  // ----------------------------------------
  // Per-output shift amounts
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_out
      logic [DW-1:0] dv;
      logic [pdc_pkg::CPH_W-1:0] cp;
      logic [AW-1:0] mag;

      always_comb begin
        dv = q.cfg[gi][pdc_pkg::CFG_DIV +: DW];
        if (dv == '0) begin
          dv = DW'(1);
        end
        cp = q.cfg[gi][pdc_pkg::CFG_CPH +: pdc_pkg::CPH_W];
        // coarse step in ticks; zero when equal
        if (cp >= dv) begin
          mag = AW'(cp - dv);
          crs_adv[gi] = 1'b0;
        end else begin
          mag = AW'(dv - cp);
          crs_adv[gi] = 1'b1;
        end
        crs_amt[gi] = AW'((mag * AW'(pdc_pkg::TICKS_PER_VCO) * AW'(dv)) / (AW'(dv) + AW'(1)));
      end

      always_comb begin
        shift_req[gi] = 1'b0;
        shift_adv[gi] = 1'b0;
        shift_amt[gi] = '0;
        if (fine_fire && fine_idx == 2'(gi)) begin
          shift_req[gi] = 1'b1;
          // direction 0 delays; direction 1 advances
          shift_adv[gi] = q.cap_dir;
          // fine setting ticks of 8 per VCO cycle
          shift_amt[gi] = AW'(q.cfg[gi][pdc_pkg::CFG_FPH +: pdc_pkg::FPH_W]);
        end else if (crs_fire && crs_idx == 2'(gi)) begin
          shift_req[gi] = crs_amt[gi] != '0;
          shift_adv[gi] = crs_adv[gi];
          shift_amt[gi] = crs_amt[gi];
        end
      end

      pdc_out_div #(
        .DIV_W(DW),
        .AMT_W(AW)
      ) u_div (
        .clk_sys(clk_sys),
        .reset(reset),
        .div_val(q.cfg[gi][pdc_pkg::CFG_DIV +: DW]),
        .shift_req(shift_req[gi]),
        .shift_adv(shift_adv[gi]),
        .shift_amt(shift_amt[gi]),
        .clk_out(div_clk[gi]),
        .fall(div_fall[gi])
      );

      // one gate per output; feedback ignores its enable
      pdc_clk_gate u_gate (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_in(div_clk[gi]),
        .gate_req(q.sync[pdc_pkg::SY_GATE + gi]),
        .prim_fall(div_fall[pdc_pkg::IDX_PRI]),
        .always_on(fbk[gi]),
        .active(active[gi]),
        .clk_out(gate_clk[gi]),
        .enabled(gate_en[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Bus decode helpers
  // ----------------------------------------
  always_comb begin
    wb_hit = wb_cyc_i & wb_stb_i & ~q.ack;
    cfg_off = wb_adr_i - ADR_W'(pdc_pkg::ADR_CFG0);
    wmerge = merge_sel(q.ctrl, wb_dat_i, wb_sel_i, pdc_pkg::CTRL_MASK);
    fb_new = wmerge[pdc_pkg::CTRL_FBDIV +: 8];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.meta = pins;
    // First stage feeds only the second
    d.sync = q.meta;
    d.step_prev = step_now;
    d.load_prev = load_now;
    if (load_now) begin
      if (q.load_len != 8'hFF) begin
        d.load_len = q.load_len + 8'h01;
      end
    end else begin
      d.load_len = 8'h00;
    end
    // latch direction and pick on rise
    if (step_rise) begin
      d.cap_pick = q.sync[pdc_pkg::SY_PICK +: 2];
      d.cap_dir = q.sync[pdc_pkg::SY_DIR];
    end
    if (fine_fire) begin
      d.fine_cnt = q.fine_cnt + 8'h01;
    end
    if (crs_fire) begin
      d.crs_cnt = q.crs_cnt + 8'h01;
    end
    d.ack = wb_hit;
    d.rdat = '0;
    if (wb_hit) begin
      if (wb_adr_i == ADR_W'(pdc_pkg::ADR_CTRL)) begin
        if (wb_we_i) begin
          d.ctrl = wmerge;
          if (fb_new < pdc_pkg::FB_DIV_MIN || fb_new > pdc_pkg::FB_DIV_MAX) begin
            d.ctrl[pdc_pkg::CTRL_FBDIV +: 8] = q.ctrl[pdc_pkg::CTRL_FBDIV +: 8];
          end
        end else begin
          d.rdat = q.ctrl;
        end
      end else if (wb_adr_i == ADR_W'(pdc_pkg::ADR_STAT)) begin
        if (!wb_we_i) begin
          d.rdat[pdc_pkg::ST_EN +: N] = gate_en;
          d.rdat[pdc_pkg::ST_PICK +: 2] = q.cap_pick;
          d.rdat[pdc_pkg::ST_DIR] = q.cap_dir;
          d.rdat[pdc_pkg::ST_FCNT +: 8] = q.fine_cnt;
          d.rdat[pdc_pkg::ST_CCNT +: 8] = q.crs_cnt;
        end
      end else if (wb_adr_i >= ADR_W'(pdc_pkg::ADR_CFG0)
          && cfg_off < ADR_W'(4 * N) && cfg_off[1:0] == 2'h0) begin
        if (wb_we_i) begin
          d.cfg[cfg_off[3:2]] = merge_sel(q.cfg[cfg_off[3:2]], wb_dat_i,
            wb_sel_i, pdc_pkg::CFG_MASK);
        end else begin
          d.rdat = q.cfg[cfg_off[3:2]];
        end
      end
      // Unmapped addresses still ack, reading zero
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
      q.ctrl <= pdc_pkg::CTRL_RST;
      q.cfg <= {N{pdc_pkg::CFG_RST}};
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign primary_out_clock = gate_clk[pdc_pkg::IDX_PRI];
  assign secondary_out_clock = gate_clk[pdc_pkg::IDX_SEC];
  assign third_out_clock = gate_clk[pdc_pkg::IDX_THR];
  assign fourth_out_clock = gate_clk[pdc_pkg::IDX_FOU];
endmodule : pdc_pll_ctrl

/* testbench/pdc_properties.sv */
// Port checker for the PLL phase and gate controller.
// Assumes a bind onto pdc_pll_ctrl; sees its ports only.
`timescale 1ns/100ps
module pdc_properties #(
  parameter int ADR_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic primary_out_gate,
  input wire logic secondary_out_gate,
  input wire logic third_out_gate,
  input wire logic fourth_out_gate,
  input wire logic primary_out_clock,
  input wire logic secondary_out_clock,
  input wire logic third_out_clock,
  input wire logic fourth_out_clock
);
  logic taken;
  logic unmapped;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign unmapped = !(wb_adr_i inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C});
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ----
  // Properties
  // ----
  // Six low samples cover the two sync flops and the output lag
  property held_low(g, c);
    !g [*6] ##0 !c |=> !c;
  endproperty
  a_ack_next: assert property (taken |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (taken && !wb_we_i && unmapped |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !primary_out_clock
    && !secondary_out_clock && !third_out_clock && !fourth_out_clock)
    else $error("activity during reset");
  a_pri_low: assert property (held_low(primary_out_gate, primary_out_clock))
    else $error("primary runs while gated");
  a_sec_low: assert property (held_low(secondary_out_gate, secondary_out_clock))
    else $error("secondary runs while gated");
  a_thr_low: assert property (held_low(third_out_gate, third_out_clock))
    else $error("third runs while gated");
  a_fou_low: assert property (held_low(fourth_out_gate, fourth_out_clock))
    else $error("fourth runs while gated");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_run: cover property ($rose(third_out_clock));
  c_stop: cover property ($fell(third_out_gate) ##[1:40] !third_out_clock);
endmodule : pdc_properties

bind pdc_pll_ctrl pdc_properties #(.ADR_W(ADR_W)) prop_u (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .primary_out_gate(primary_out_gate),
  .secondary_out_gate(secondary_out_gate), .third_out_gate(third_out_gate),
  .fourth_out_gate(fourth_out_gate), .primary_out_clock(primary_out_clock),
  .secondary_out_clock(secondary_out_clock), .third_out_clock(third_out_clock),
  .fourth_out_clock(fourth_out_clock)
);

/* testbench/pdc_fabric_model.sv */
// Fabric logic driving the phase and gate pins.
// Assumes one tick per clk_sys cycle, eight ticks per VCO cycle.
`timescale 1ns/100ps
module pdc_fabric_model (
  input wire logic clk_sys,
  output logic [1:0] output_pick_code,
  output logic shift_direction,
  output logic fine_step_pulse,
  output logic divider_shift_pulse,
  output logic [3:0] gate
);
  localparam int VCO = pdc_pkg::TICKS_PER_VCO;
  // Divide 1, coarse 1: 2.5*2+2 = 7 divider periods
  localparam int LOAD_GAP = ((5 * 2 + 1) / 2 + 2) * VCO;
  initial begin
    output_pick_code <= 2'h0;
    shift_direction <= 1'b0;
    fine_step_pulse <= 1'b0;
    divider_shift_pulse <= 1'b0;
    gate <= 4'h0;
  end
  // ----
  // Pin sequences
  // ----
  // setup, hold, width
  task automatic fine_step(input logic [1:0] code, input logic dir);
    @(posedge clk_sys);
    output_pick_code <= code;
    shift_direction <= dir;
    repeat (2) @(posedge clk_sys);
    fine_step_pulse <= 1'b1;
    repeat (pdc_pkg::STEP_MIN_VCO * VCO) @(posedge clk_sys);
    fine_step_pulse <= 1'b0;
    // Low time covers the hold and the next pulse spacing
    repeat ((pdc_pkg::HOLD_VCO + pdc_pkg::STEP_MIN_VCO) * VCO) @(posedge clk_sys);
  endtask : fine_step
  task automatic div_shift(input logic [1:0] code);
    @(posedge clk_sys);
    output_pick_code <= code;
    repeat (2) @(posedge clk_sys);
    divider_shift_pulse <= 1'b1;
    repeat (pdc_pkg::LOAD_MIN_CYC + 1) @(posedge clk_sys);
    divider_shift_pulse <= 1'b0;
    repeat (LOAD_GAP) @(posedge clk_sys);
  endtask : div_shift
  task automatic set_gates(input logic [3:0] g);
    @(posedge clk_sys);
    gate <= g;
  endtask : set_gates
endmodule : pdc_fabric_model

/* testbench/pdc_testbench.sv */
// Self-checking bench for the PLL phase and gate controller.
// Assumes the fabric model drives the phase and gate pins.
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] pick;
  logic dir;
  logic step;
  logic load;
  logic [3:0] gate;
  logic [3:0] outs;
  logic [3:0] seen;
  logic [31:0] rd;
  logic [7:0] fb_wr [4] = '{8'h80, 8'h00, 8'h81, 8'h01};
  logic [7:0] fb_exp [4] = '{8'h80, 8'h80, 8'h80, 8'h01};
  int n_mismatch = 0;
  int num_checks = 0;
  int gap;

  always #50 clk_sys = ~clk_sys;

  pdc_pll_ctrl dut_u (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .output_pick_code(pick), .shift_direction(dir), .fine_step_pulse(step), .divider_shift_pulse(load),
    .primary_out_gate(gate[0]), .secondary_out_gate(gate[1]), .third_out_gate(gate[2]),
    .fourth_out_gate(gate[3]), .primary_out_clock(outs[0]), .secondary_out_clock(outs[1]),
    .third_out_clock(outs[2]), .fourth_out_clock(outs[3])
  );
  pdc_fabric_model fab_u (
    .clk_sys(clk_sys), .output_pick_code(pick), .shift_direction(dir), .fine_step_pulse(step),
    .divider_shift_pulse(load), .gate(gate)
  );

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Waits on ack alone; the watchdog cuts a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, 4'hF);
    check(what, rd & mask, exp);
  endtask : rchk

  task automatic watch(input int cyc);
    seen = 4'h0;
    repeat (cyc) begin
      @(posedge clk_sys);
      seen = seen | outs;
    end
  endtask : watch

  // Cycles from a primary rising edge to the next rise of output b
  task automatic lag(input int b);
    while (outs[0] !== 1'b0) @(posedge clk_sys);
    while (outs[0] !== 1'b1) @(posedge clk_sys);
    gap = 0;
    while (outs[b] !== 1'b1) begin
      @(posedge clk_sys);
      gap++;
    end
  endtask : lag

  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ----
  // Sequence
  // ----
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    watch(40);
    check("gated_clocks", {28'h0, seen}, 32'h0000_0000);
    rchk("ctrl_rst", pdc_pkg::ADR_CTRL, 32'hFFFF_FFFF, pdc_pkg::CTRL_RST);
    for (int i = 0; i < 4; i++) begin
      rchk("cfg_rst", pdc_pkg::ADR_CFG0 + 8'(4 * i), 32'hFFFF_FFFF, pdc_pkg::CFG_RST);
    end
    rchk("unmapped", 8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1'b1, pdc_pkg::ADR_STAT, 32'hFFFF_FFFF, 4'hF);
    rchk("stat_ro", pdc_pkg::ADR_STAT, 32'h00FF_FF00, 32'h0000_0000);
    wb(1'b1, 8'h14, 32'hFFFF_FFFF, 4'h3);
    rchk("cfg_lanes", 8'h14, 32'hFFFF_FFFF, 32'h0001_07FF);
    wb(1'b1, 8'h14, pdc_pkg::CFG_RST, 4'hF);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, pdc_pkg::ADR_CTRL, {16'h0, fb_wr[i], 8'h0F}, 4'hF);
      rchk("fb_div", pdc_pkg::ADR_CTRL, 32'hFFFF_FFFF, {16'h0, fb_exp[i], 8'h0F});
    end
    for (int i = 0; i < 4; i++) begin
      fab_u.fine_step(2'(i), 1'(i));
      rchk("step_latch", pdc_pkg::ADR_STAT, 32'h00FF_FF70, {16'h0, 8'(i + 1), 1'b0, 1'(i), 2'(i), 4'h0});
    end
    fab_u.div_shift(pdc_pkg::PICK_THR);
    fab_u.div_shift(pdc_pkg::PICK_FOU);
    rchk("shift_cnt", pdc_pkg::ADR_STAT, 32'h00FF_FF00, 32'h0002_0400);
    // Secondary made inactive: its gate must be ignored
    wb(1'b1, pdc_pkg::ADR_CTRL, 32'h0000_010D, 4'hF);
    fab_u.set_gates(4'hF);
    repeat (30) @(posedge clk_sys);
    watch(40);
    check("gates_on", {28'h0, seen}, 32'h0000_000D);
    // Fourth delayed one tick, primary advanced one: fourth lags by two
    lag(3);
    check("fine_lag", gap, 32'h0000_0002);
    // Third advanced like primary; its coarse shift with both set to 1 is none
    lag(2);
    check("coarse_none", gap, 32'h0000_0000);
    fab_u.set_gates(4'hB);
    repeat (30) @(posedge clk_sys);
    watch(40);
    check("third_off", {28'h0, seen}, 32'h0000_0009);
    fab_u.set_gates(4'hF);
    repeat (30) @(posedge clk_sys);
    watch(40);
    check("third_back", {28'h0, seen}, 32'h0000_000D);
    summarize();
  end

  initial begin
    repeat (6000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
endmodule : testbench
